// ---- hw/pmg_gateway_top.sv ----
// Operation
// - Pin selector bits 2:0 choose LED pin 0..7 for intensity access; default 0.
// - Intensity write stores index 0..255 for the selected pin.
// - Intensity read returns selected pin index; power-up value is on or off level.
// - Writing 0xDE then 0x00 to register 0xB1 resets the device.
// - Config bits 5:4: 01 enables gateway, 00 off, others reserved.
// - Config bit 3: 0 writes shadow memory, 1 reads it.
// - Base address is a multiple of eight from 0x00 to 0x78.
// - Every shadow memory transfer is an eight-byte burst at the base.
// - Gateway works in active, doze and sleep; sleep preferred for writes.
// - Write burst: mode on, base, eight bytes to 0..7, then 000.
// - Read burst: mode on read, base, read 0..7, then 000.
// - Applied write burst in active or doze sets flag 5, asserts interrupt.
// - Sleep apply may take 30 ms; host waits between bursts.
// - Reading interrupt source clears burst flag and releases interrupt.
// - Finished burn sets flag 6 and asserts interrupt.
// - After any reset burned parameters reload into shadow memory.
// - Each burn counts up from zero; fourth burn falls back to factory.
// - Unlock: 0x62 to 0xAC, 0x9D to 0xAD, 0xA5 to base, STOP each.
// - Fourth write 0x5A to base with STOP starts the burn.
// - Interrupt line low while any flag set; source read clears all.
// - Burned store used only with count 1..3 and valid bit set.
`timescale 1ns/1ns
module pmg_gateway_top
  import pmg_pkg::*;
#(
  parameter int SLEEP_APPLY_CYC = SLEEP_APPLY_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic nv_init,
  input wire logic [1:0] op_mode,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic i2c_stop,
  input wire logic [7:0] output_powerup_state,
  input wire logic [7:0] led_on_level,
  input wire logic [7:0] led_off_level,
  output logic [7:0] reg_rdata,
  output logic interrupt_line_n,
  output logic soft_reset_out,
  output logic [7:0][7:0] led_intensity
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic rst_int;
  logic [2:0] pin_sel_reg;
  logic [7:0][7:0] intensity_reg;
  logic soft_arm_reg;
  logic soft_reset_reg;
  logic [2:0] cfg_reg;
  logic [7:0] base_reg;
  logic [7:0][7:0] stage_reg;
  logic [7:0] stage_mask_reg;
  logic pend_reg;
  logic [21:0] delay_reg;
  logic flag_apply_reg;
  logic flag_burn_reg;
  logic flag_apply_next;
  logic flag_burn_next;
  logic irq_n_reg;
  logic [7:0] rdata_reg;
  logic gw_on;
  logic in_window;
  logic wr_pin;
  logic wr_int;
  logic wr_cfg;
  logic wr_base;
  logic wr_sw;
  logic end_burst;
  logic apply;
  logic irq_clear;
  logic mem_ready;
  logic [7:0] mem_rd_data;
  logic burn_start;
  logic burn_done;
  logic [2:0] burn_count;
  logic burned_valid;
  logic ul_armed;
  logic key_write;

  assign rst_int = sys_rst || soft_reset_reg;
  assign gw_on = pmg_gw_on(cfg_reg);
  assign in_window = gw_on && reg_addr < ADDR_GW_WIN_END;
  assign wr_pin = reg_wr && !in_window && reg_addr == ADDR_PIN_SEL;
  assign wr_int = reg_wr && !in_window && reg_addr == ADDR_INTENSITY;
  assign wr_cfg = reg_wr && !in_window && reg_addr == ADDR_GW_CFG;
  assign wr_base = reg_wr && !in_window && reg_addr == ADDR_GW_BASE;
  assign wr_sw = reg_wr && !in_window && reg_addr == ADDR_SW_RESET;
  assign key_write = ul_armed && (reg_wdata == BURN_ARM_VALUE || reg_wdata == BURN_GO_VALUE);
  // A burst only counts once all eight bytes arrived
  assign end_burst = wr_cfg && gw_on && !cfg_reg[0] && reg_wdata[5:3] == CFG_RST
    && &stage_mask_reg;
  // A burn starting in the same cycle would swallow the burst, so the apply waits
  assign apply = pend_reg && delay_reg == 22'h0 && mem_ready && !burn_start;
  assign irq_clear = reg_rd && !in_window && reg_addr == ADDR_IRQ_SRC;

  assign reg_rdata = rdata_reg;
  assign interrupt_line_n = irq_n_reg;
  assign soft_reset_out = soft_reset_reg;
  assign led_intensity = intensity_reg;

  // ----------------------------------------
  // LED pin selection and intensity
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst_int) begin
      pin_sel_reg <= PIN_SEL_RST;
    end else if (wr_pin) begin
      pin_sel_reg <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst_int) begin
      for (int i = 0; i < 8; i++) begin
        intensity_reg[i] <= output_powerup_state[i] ? led_on_level : led_off_level;
      end
    end else if (wr_int) begin
      intensity_reg[pin_sel_reg] <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Software reset
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      soft_arm_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_sw && soft_arm_reg && reg_wdata == SW_RESET_KEY_SECOND;
      if (reg_wr) begin
        soft_arm_reg <= wr_sw && reg_wdata == SW_RESET_KEY_FIRST;
      end
    end
  end

  // ----------------------------------------
  // Gateway configuration and base
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst_int) begin
      cfg_reg <= CFG_RST;
    end else if (wr_cfg) begin
      cfg_reg <= reg_wdata[5:3];
    end
  end

  // Unaligned or oversize values are folded into range instead of kept
  always_ff @(posedge clock) begin
    if (rst_int) begin
      base_reg <= BASE_RST;
    end else if (wr_base && !key_write) begin
      base_reg <= reg_wdata & BASE_ALIGN_MASK;
    end
  end

  // ----------------------------------------
  // Burst staging
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst_int) begin
      stage_mask_reg <= 8'h00;
    end else if (wr_cfg && !gw_on) begin
      stage_mask_reg <= 8'h00;
    end else if (reg_wr && in_window && !cfg_reg[0]) begin
      stage_reg[reg_addr[2:0]] <= reg_wdata;
      stage_mask_reg[reg_addr[2:0]] <= 1'b1;
    end
  end

  // Sleep defers the apply; the host must not start a new burst meanwhile
  always_ff @(posedge clock) begin
    if (rst_int) begin
      pend_reg <= 1'b0;
      delay_reg <= 22'h0;
    end else if (end_burst) begin
      pend_reg <= 1'b1;
      delay_reg <= op_mode == OPM_SLEEP ? 22'(SLEEP_APPLY_CYC) : 22'h0;
    end else if (pend_reg && delay_reg != 22'h0) begin
      delay_reg <= delay_reg - 22'h1;
    end else if (apply) begin
      pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt source
  // ----------------------------------------
  always_comb begin
    flag_apply_next = (apply && op_mode != OPM_SLEEP) || (flag_apply_reg && !irq_clear);
    flag_burn_next = burn_done || (flag_burn_reg && !irq_clear);
  end

  always_ff @(posedge clock) begin
    if (rst_int) begin
      flag_apply_reg <= 1'b0;
      flag_burn_reg <= 1'b0;
      irq_n_reg <= 1'b1;
    end else begin
      flag_apply_reg <= flag_apply_next;
      flag_burn_reg <= flag_burn_next;
      irq_n_reg <= !(flag_apply_next || flag_burn_next);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst_int) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      if (in_window) begin
        rdata_reg <= cfg_reg[0] ? mem_rd_data : 8'h00;
      end else if (reg_addr == ADDR_IRQ_SRC) begin
        rdata_reg <= 8'h00;
        rdata_reg[IRQ_APPLY_BIT] <= flag_apply_reg;
        rdata_reg[IRQ_BURN_BIT] <= flag_burn_reg;
      end else if (reg_addr == ADDR_STORE_STATUS) begin
        rdata_reg <= {4'h0, burned_valid, burn_count};
      end else if (reg_addr == ADDR_PIN_SEL) begin
        rdata_reg <= {5'h00, pin_sel_reg};
      end else if (reg_addr == ADDR_INTENSITY) begin
        rdata_reg <= intensity_reg[pin_sel_reg];
      end else if (reg_addr == ADDR_GW_CFG) begin
        rdata_reg <= {2'h0, cfg_reg, 3'h0};
      end else if (reg_addr == ADDR_GW_BASE) begin
        rdata_reg <= base_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  pmg_param_mem u_mem (
    .clock(clock),
    .rst(rst_int),
    .nv_init(nv_init),
    .wr_req(apply),
    .wr_base(base_reg),
    .wr_data(stage_reg),
    .wr_ready(mem_ready),
    .rd_idx(pmg_mem_idx(base_reg, reg_addr[2:0])),
    .rd_data(mem_rd_data),
    .burn_start(burn_start),
    .burn_done(burn_done),
    .burn_count(burn_count),
    .burned_valid(burned_valid)
  );

  pmg_burn_unlock u_unlock (
    .clock(clock),
    .rst(rst_int),
    .wr(reg_wr),
    .addr(reg_addr),
    .data(reg_wdata),
    .stop(i2c_stop),
    .armed(ul_armed),
    .burn_start(burn_start)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst_int);

  AST_PIN_SEL: assert property (wr_pin |=> pin_sel_reg == $past(reg_wdata[2:0]))
    else $error("pin selector not updated");
  AST_INT_WRITE: assert property (wr_int |=>
    intensity_reg[$past(pin_sel_reg)] == $past(reg_wdata))
    else $error("intensity not stored for selected pin");
  AST_INT_READ: assert property ((reg_rd && !in_window && reg_addr == ADDR_INTENSITY) |=>
    reg_rdata == $past(intensity_reg[pin_sel_reg]))
    else $error("intensity read mismatch");
  AST_SOFT_RESET: assert property (@(posedge clock) disable iff (sys_rst)
    (wr_sw && reg_wdata == SW_RESET_KEY_FIRST) ##1 (!reg_wr [*2]) ##1
    (wr_sw && reg_wdata == SW_RESET_KEY_SECOND) |=> soft_reset_out)
    else $error("soft reset key pair ignored");
  AST_BASE_RANGE: assert property (base_reg[2:0] == 3'h0 && base_reg <= BASE_MAX)
    else $error("base address out of range");
  AST_APPLY_FLAG: assert property ((apply && op_mode != OPM_SLEEP) |=>
    (flag_apply_reg && !interrupt_line_n))
    else $error("applied burst not flagged");
  AST_SLEEP_WAIT: assert property ((end_burst && op_mode == OPM_SLEEP) |=>
    (pend_reg && delay_reg == 22'(SLEEP_APPLY_CYC)))
    else $error("sleep apply delay not loaded");
  AST_IRQ_CLEAR: assert property ((irq_clear && !apply && !burn_done) |=>
    (!flag_apply_reg && !flag_burn_reg && interrupt_line_n))
    else $error("source read did not clear");
  AST_BURN_FLAG: assert property (burn_done |=> (flag_burn_reg && !interrupt_line_n))
    else $error("burn end not flagged");
  AST_IRQ_LINE: assert property (interrupt_line_n == !(flag_apply_reg || flag_burn_reg))
    else $error("interrupt line disagrees with flags");
endmodule : pmg_gateway_top

// ---- hw/pmg_pkg.sv ----
package pmg_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_IRQ_SRC = 8'h00;
  localparam logic [7:0] ADDR_GW_WIN_END = 8'h08;
  localparam logic [7:0] ADDR_STORE_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PIN_SEL = 8'h0B;
  localparam logic [7:0] ADDR_INTENSITY = 8'h0C;
  localparam logic [7:0] ADDR_GW_CFG = 8'h0D;
  localparam logic [7:0] ADDR_GW_BASE = 8'h0E;
  localparam logic [7:0] ADDR_KEY_HIGH = 8'hAC;
  localparam logic [7:0] ADDR_KEY_LOW = 8'hAD;
  localparam logic [7:0] ADDR_SW_RESET = 8'hB1;
  // ----------------------------------------
  // Key values and fields
  // ----------------------------------------
  localparam logic [7:0] SW_RESET_KEY_FIRST = 8'hDE;
  localparam logic [7:0] SW_RESET_KEY_SECOND = 8'h00;
  localparam logic [7:0] KEY_HIGH_VALUE = 8'h62;
  localparam logic [7:0] KEY_LOW_VALUE = 8'h9D;
  localparam logic [7:0] BURN_ARM_VALUE = 8'hA5;
  localparam logic [7:0] BURN_GO_VALUE = 8'h5A;
  localparam int CFG_LSB = 3;
  localparam logic [1:0] GW_MODE_ON = 2'h1;
  localparam int IRQ_APPLY_BIT = 5;
  localparam int IRQ_BURN_BIT = 6;
  localparam int STATUS_VALID_BIT = 3;
  localparam logic [7:0] BASE_MAX = 8'h78;
  localparam logic [7:0] BASE_ALIGN_MASK = 8'h78;
  localparam logic [2:0] BURN_LIMIT = 3'h3;
  localparam logic [2:0] BURN_COUNT_SAT = 3'h4;
  localparam logic [6:0] MEM_LAST = 7'h7F;
  localparam logic [1:0] OPM_SLEEP = 2'h2;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [2:0] PIN_SEL_RST = 3'h0;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [7:0] BASE_RST = 8'h00;
  localparam logic [7:0] FACTORY_FILL = 8'h00;
  localparam int CLK_HZ = 125_000_000;
  localparam int SLEEP_APPLY_MS = 30;
  localparam int SLEEP_APPLY_CYCLES = SLEEP_APPLY_MS * (CLK_HZ / 1000);

  function automatic logic pmg_gw_on(input logic [2:0] cfg);
    return cfg[2:1] == GW_MODE_ON;
  endfunction : pmg_gw_on

  function automatic logic [6:0] pmg_mem_idx(input logic [7:0] base, input logic [2:0] off);
    return base[6:0] | {4'h0, off};
  endfunction : pmg_mem_idx
endpackage : pmg_pkg

// ---- hw/pmg_param_mem.sv ----
`timescale 1ns/1ns
module pmg_param_mem
  import pmg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic nv_init,
  input wire logic wr_req,
  input wire logic [7:0] wr_base,
  input wire logic [7:0][7:0] wr_data,
  output logic wr_ready,
  input wire logic [6:0] rd_idx,
  output logic [7:0] rd_data,
  input wire logic burn_start,
  output logic burn_done,
  output logic [2:0] burn_count,
  output logic burned_valid
);
  typedef enum logic [1:0] {MEM_LOAD, MEM_IDLE, MEM_BURN} pmg_mem_state_e;
  pmg_mem_state_e state_reg;
  logic [6:0] idx_reg;
  logic [7:0] shadow_reg [128];
  logic [7:0] store_reg [128];
  logic [2:0] count_reg;
  logic valid_reg;
  logic burn_done_reg;
  logic use_store;

  assign use_store = valid_reg && count_reg != 3'h0 && count_reg <= BURN_LIMIT;
  assign wr_ready = state_reg == MEM_IDLE;
  assign rd_data = shadow_reg[rd_idx];
  assign burn_done = burn_done_reg;
  assign burn_count = count_reg;
  assign burned_valid = valid_reg;

  // ----------------------------------------
  // Sequencer: reload after reset, burn, burst write
  // ----------------------------------------
  always_ff @(posedge clock) begin
    burn_done_reg <= 1'b0;
    if (rst) begin
      state_reg <= MEM_LOAD;
      idx_reg <= 7'h0;
    end else begin
      case (state_reg)
        MEM_LOAD: begin
          shadow_reg[idx_reg] <= use_store ? store_reg[idx_reg] : FACTORY_FILL;
          idx_reg <= idx_reg + 7'h1;
          if (idx_reg == MEM_LAST) begin
            state_reg <= MEM_IDLE;
          end
        end
        MEM_IDLE: begin
          if (burn_start) begin
            state_reg <= MEM_BURN;
            idx_reg <= 7'h0;
          end else if (wr_req) begin
            for (int k = 0; k < 8; k++) begin
              shadow_reg[pmg_mem_idx(wr_base, 3'(k))] <= wr_data[k];
            end
          end
        end
        default: begin
          store_reg[idx_reg] <= shadow_reg[idx_reg];
          idx_reg <= idx_reg + 7'h1;
          if (idx_reg == MEM_LAST) begin
            state_reg <= MEM_IDLE;
            burn_done_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // Counter and validity live through every reset except a factory erase
  always_ff @(posedge clock) begin
    if (nv_init) begin
      count_reg <= 3'h0;
      valid_reg <= 1'b0;
    end else if (!rst && state_reg == MEM_BURN && idx_reg == MEM_LAST) begin
      if (count_reg != BURN_COUNT_SAT) begin
        count_reg <= count_reg + 3'h1;
      end
      valid_reg <= count_reg < BURN_LIMIT;
    end
  end

  AST_BURN_COUNT: assert property (@(posedge clock) disable iff (rst || nv_init)
    (state_reg == MEM_BURN && idx_reg == MEM_LAST && count_reg < BURN_COUNT_SAT)
    |=> count_reg == $past(count_reg) + 3'h1)
    else $error("burn counter did not advance");
endmodule : pmg_param_mem

// ---- hw/pmg_burn_unlock.sv ----
`timescale 1ns/1ns
module pmg_burn_unlock
  import pmg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] data,
  input wire logic stop,
  output logic armed,
  output logic burn_start
);
  typedef enum logic [1:0] {UL_WAIT_HIGH, UL_WAIT_LOW, UL_WAIT_ARM, UL_WAIT_GO} pmg_ul_state_e;
  pmg_ul_state_e stage_reg;
  logic wait_stop_reg;
  logic burn_reg;
  logic hit;

  // ----------------------------------------
  // Expected write for each stage
  // ----------------------------------------
  always_comb begin
    case (stage_reg)
      UL_WAIT_HIGH: hit = addr == ADDR_KEY_HIGH && data == KEY_HIGH_VALUE;
      UL_WAIT_LOW: hit = addr == ADDR_KEY_LOW && data == KEY_LOW_VALUE;
      UL_WAIT_ARM: hit = addr == ADDR_GW_BASE && data == BURN_ARM_VALUE;
      default: hit = addr == ADDR_GW_BASE && data == BURN_GO_VALUE;
    endcase
  end

  assign armed = stage_reg == UL_WAIT_ARM || stage_reg == UL_WAIT_GO;
  assign burn_start = burn_reg;

  // Two writes without a STOP between them break the sequence too
  always_ff @(posedge clock) begin
    burn_reg <= 1'b0;
    if (rst) begin
      stage_reg <= UL_WAIT_HIGH;
      wait_stop_reg <= 1'b0;
    end else if (wr) begin
      if (hit && !wait_stop_reg) begin
        wait_stop_reg <= 1'b1;
      end else begin
        stage_reg <= UL_WAIT_HIGH;
        wait_stop_reg <= 1'b0;
      end
    end else if (stop && wait_stop_reg) begin
      wait_stop_reg <= 1'b0;
      if (stage_reg == UL_WAIT_GO) begin
        stage_reg <= UL_WAIT_HIGH;
        burn_reg <= 1'b1;
      end else begin
        stage_reg <= pmg_ul_state_e'(stage_reg + 2'h1);
      end
    end
  end

  sequence s_go_written;
    wr && !wait_stop_reg && stage_reg == UL_WAIT_GO && addr == ADDR_GW_BASE
      && data == BURN_GO_VALUE;
  endsequence
  sequence s_stop_only;
    !wr && stop;
  endsequence

  AST_BURN_ON_GO: assert property (@(posedge clock) disable iff (rst)
    s_go_written ##1 s_stop_only |=> burn_start)
    else $error("burn not started after final key");
  AST_ABORT: assert property (@(posedge clock) disable iff (rst)
    (wr && (!hit || wait_stop_reg)) |=> (stage_reg == UL_WAIT_HIGH && !burn_start))
    else $error("bad write did not abandon unlock");
endmodule : pmg_burn_unlock

// ---- testbench/pmg_host_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Register host on the far side
// ----------------------------------------
module pmg_host_model (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic i2c_stop
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    i2c_stop = 1'b0;
  end

  // Each write gets its own STOP, which the burn keys need anyway
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    // Released lines must not keep the old value
    reg_addr = ~a;
    reg_wdata = ~d;
    i2c_stop = 1'b1;
    @(negedge clock);
    i2c_stop = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : pmg_host_model

// ---- testbench/tb_parameter_memory_gateway.sv ----
`timescale 1ns/1ns
module tb_parameter_memory_gateway
  import pmg_pkg::*;
;
  localparam int SLP = 20;
  localparam logic [7:0] PUP = 8'hA5;
  localparam logic [7:0] LON = 8'hC3;
  localparam logic [7:0] LOFF = 8'h3C;
  logic clock = 1'b0;
  logic sys_rst;
  logic nv_init;
  logic [1:0] op_mode;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic i2c_stop;
  logic [7:0] reg_rdata;
  logic interrupt_line_n;
  logic soft_reset_out;
  logic [7:0][7:0] led_intensity;
  int miscompares = 0;
  int num_checks = 0;
  int srst_seen = 0;

  always #4 clock = ~clock;

  pmg_gateway_top #(.SLEEP_APPLY_CYC(SLP)) pmg_gateway_top_i (
    .clock(clock), .sys_rst(sys_rst), .nv_init(nv_init), .op_mode(op_mode),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .i2c_stop(i2c_stop), .output_powerup_state(PUP), .led_on_level(LON),
    .led_off_level(LOFF), .reg_rdata(reg_rdata), .interrupt_line_n(interrupt_line_n),
    .soft_reset_out(soft_reset_out), .led_intensity(led_intensity)
  );

  pmg_host_model pmg_host_model_i (
    .clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .i2c_stop(i2c_stop)
  );

  always @(posedge clock) begin
    if (soft_reset_out === 1'b1) begin
      srst_seen <= srst_seen + 1;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    pmg_host_model_i.rd(a, d);
    chk(d, e);
  endtask : rchk

  function automatic logic [7:0] lvl(input int p);
    return PUP[p] ? LON : LOFF;
  endfunction : lvl

  // Bounded so a lost interrupt fails instead of hanging
  task automatic wait_irq();
    int n;
    n = 0;
    while (interrupt_line_n !== 1'b0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk({7'h0, interrupt_line_n}, 8'h00);
  endtask : wait_irq

  task automatic burst_wr(input logic [7:0] b, input logic [7:0] f);
    pmg_host_model_i.wr(ADDR_GW_CFG, 8'h10);
    pmg_host_model_i.wr(ADDR_GW_BASE, b);
    for (int i = 0; i < 8; i++) pmg_host_model_i.wr(8'(i), f + 8'(i));
    pmg_host_model_i.wr(ADDR_GW_CFG, 8'h00);
  endtask : burst_wr

  task automatic burst_chk(input logic [7:0] b, input logic [7:0] f, input logic inc);
    pmg_host_model_i.wr(ADDR_GW_CFG, 8'h18);
    pmg_host_model_i.wr(ADDR_GW_BASE, b);
    rchk(ADDR_GW_CFG, 8'h18);
    for (int i = 0; i < 8; i++) rchk(8'(i), inc ? f + 8'(i) : f);
    pmg_host_model_i.wr(ADDR_GW_CFG, 8'h00);
  endtask : burst_chk

  task automatic burn(input logic [7:0] kl);
    pmg_host_model_i.wr(ADDR_KEY_HIGH, KEY_HIGH_VALUE);
    pmg_host_model_i.wr(ADDR_KEY_LOW, kl);
    pmg_host_model_i.wr(ADDR_GW_BASE, BURN_ARM_VALUE);
    pmg_host_model_i.wr(ADDR_GW_BASE, BURN_GO_VALUE);
  endtask : burn

  task automatic soft_rst();
    pmg_host_model_i.wr(ADDR_SW_RESET, SW_RESET_KEY_FIRST);
    pmg_host_model_i.wr(ADDR_SW_RESET, SW_RESET_KEY_SECOND);
    repeat (140) @(negedge clock);
  endtask : soft_rst

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #300000;
    miscompares++;
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    nv_init = 1'b1;
    op_mode = 2'h0;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    nv_init = 1'b0;
    for (int p = 0; p < 8; p++) chk(led_intensity[p], lvl(p));
    rchk(ADDR_INTENSITY, lvl(0));
    rchk(ADDR_GW_BASE, 8'h00);
    for (int p = 0; p < 8; p++) begin
      pmg_host_model_i.wr(ADDR_PIN_SEL, 8'(p));
      pmg_host_model_i.wr(ADDR_INTENSITY, 8'hF8 + 8'(p));
    end
    for (int p = 0; p < 8; p++) begin
      pmg_host_model_i.wr(ADDR_PIN_SEL, 8'(p));
      rchk(ADDR_PIN_SEL, 8'(p));
      rchk(ADDR_INTENSITY, 8'hF8 + 8'(p));
      chk(led_intensity[p], 8'hF8 + 8'(p));
    end
    repeat (130) @(negedge clock);
    burst_wr(8'h78, 8'h90);
    wait_irq();
    rchk(ADDR_IRQ_SRC, 8'h20);
    chk({7'h0, interrupt_line_n}, 8'h01);
    burst_chk(8'h78, 8'h90, 1'b1);
    op_mode = OPM_SLEEP;
    burst_wr(8'h08, 8'h40);
    repeat (SLP + 10) @(negedge clock);
    chk({7'h0, interrupt_line_n}, 8'h01);
    op_mode = 2'h0;
    burst_chk(8'h08, 8'h40, 1'b1);
    burn(8'h9C);
    repeat (150) @(negedge clock);
    chk({7'h0, interrupt_line_n}, 8'h01);
    rchk(ADDR_STORE_STATUS, 8'h00);
    rchk(ADDR_GW_BASE, BURN_GO_VALUE & BASE_ALIGN_MASK);
    // Fill the whole shadow memory in doze before the first real burn
    op_mode = 2'h1;
    for (int k = 0; k < 16; k++) begin
      burst_wr(8'(k * 8), 8'h90);
      wait_irq();
      rchk(ADDR_IRQ_SRC, 8'h20);
    end
    op_mode = 2'h0;
    burn(KEY_LOW_VALUE);
    wait_irq();
    rchk(ADDR_IRQ_SRC, 8'h40);
    rchk(ADDR_STORE_STATUS, 8'h09);
    rchk(ADDR_GW_BASE, BASE_MAX);
    soft_rst();
    chk(8'(srst_seen), 8'h01);
    chk(led_intensity[7], lvl(7));
    burst_chk(8'h78, 8'h90, 1'b1);
    burst_chk(8'h00, 8'h90, 1'b1);
    for (int k = 0; k < 3; k++) begin
      burn(KEY_LOW_VALUE);
      wait_irq();
      rchk(ADDR_IRQ_SRC, 8'h40);
    end
    rchk(ADDR_STORE_STATUS, 8'h04);
    soft_rst();
    chk(8'(srst_seen), 8'h02);
    burst_chk(8'h78, FACTORY_FILL, 1'b0);
    end_sim();
  end
endmodule : tb_parameter_memory_gateway
